// ===== rtl/pim_pkg.sv
package pim_pkg;

    // ----------------------------------------
    // register offsets
    // ----------------------------------------
    localparam logic [7:0] OFS_CHARGER_STATUS   = 8'h01;
    localparam logic [7:0] OFS_REGULATOR_STATUS = 8'h02;
    localparam logic [7:0] OFS_CHARGER_MASK     = 8'h03;
    localparam logic [7:0] OFS_REGULATOR_MASK   = 8'h04;
    localparam logic [7:0] OFS_CHARGER_ACK      = 8'h05;
    localparam logic [7:0] OFS_REGULATOR_ACK    = 8'h06;
    localparam logic [7:0] OFS_CHARGER_CONFIG   = 8'h07;

    // ----------------------------------------
    // reset values
    // ----------------------------------------
    localparam logic [7:0] RST_MASK   = 8'hFF;
    localparam logic [7:0] RST_ACK    = 8'h00;
    localparam logic [7:0] RST_CONFIG = 8'h1B;
    localparam logic [7:0] RST_ZERO   = 8'h00;

    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int REG_RESERVED_BIT   = 4;
    localparam int CFG_AUTO_ON_INHIBIT = 7;
    localparam int CFG_CHARGER_RESTART = 6;
    localparam int CFG_TIMER_ENABLE    = 5;
    localparam int CFG_RATE_HI         = 4;
    localparam int CFG_RATE_LO         = 3;
    localparam int CFG_USB_LIMIT_SEL   = 2;
    localparam int CFG_USB_CHARGE_OK   = 1;
    localparam int CFG_CHARGE_ENABLE   = 0;

    localparam int NUM_SOURCES = 16;

endpackage

// ===== rtl/pim_ack_bit.sv
module pim_ack_bit
(
    input  wire logic clock,
    input  wire logic sys_rst,
    input  wire logic cond,
    input  wire logic mask,
    input  wire logic set_ack,
    output logic      pending,
    output logic      ack
);
    logic prev_reg;
    logic ack_reg;
    logic flag_reg;
    logic ack_next;
    logic flag_next;
    wire  rise = cond & ~prev_reg;

    // acknowledge only taken while the condition stands; clears when it goes
    assign ack_next  = cond & (ack_reg | (set_ack & flag_reg));
    // unmasked rising edge arms the flag, ack or loss of condition retires it
    assign flag_next = cond & ((flag_reg & ~ack_next) | (rise & ~mask));

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            prev_reg <= 1'b0;
            ack_reg  <= 1'b0;
            flag_reg <= 1'b0;
        end
        else
        begin
            prev_reg <= cond;
            ack_reg  <= ack_next;
            flag_reg <= flag_next;
        end
    end

    assign pending = flag_reg & ~mask & ~ack_reg;
    assign ack     = ack_reg;
endmodule

// ===== rtl/pim_irq_ctrl.sv
// Functional notes
// RULE1: regulator mask bit n blocks regulator status n; all bits rw, reset one.
// RULE2: regulator mask bit 4 reserved, rw, resets one, affects nothing.
// RULE3: one acknowledge bit per charger status; set ack stops that interrupt.
// RULE4: one acknowledge bit per regulator status; set ack stops that interrupt.
// RULE5: after ack, output shows next pending; high only when none remain.
// RULE6: charger ack bit self-clears when its status condition goes away.
// RULE7: regulator ack bit self-clears when its status condition goes away.
// RULE8: charger ack register read-only at 05h, reset zero.
// RULE9: regulator ack register read-only at 06h, reset zero, bit 4 reserved.
// RULE10: host should normally not access the acknowledge registers.
// RULE11: charger configuration at 07h, all bits rw, resets to 1Bh.
// RULE12: configuration fields: inhibit, restart, timer, rate, usb limit, usb ok, enable.
// RULE13: rising regulator status edge drives interrupt low unless masked.
// RULE14: charger mask bit n blocks charger status n; resets to all ones.
// RULE15: regulator mask at 04h, resets to all ones.
// RULE16: fixed priority, lowest register then bit; status read acknowledges it.
// RULE17: reset clears acks and sets masks so interrupt output stays high.
module pim_irq_ctrl
(
    input  wire logic       clock,
    input  wire logic       sys_rst,
    input  wire logic [7:0] charger_status_pin,
    input  wire logic [7:0] regulator_status_pin,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_write,
    input  wire logic       reg_read,
    output logic      [7:0] reg_rdata,
    output logic            irq_n,
    output logic            auto_on_inhibit,
    output logic            charger_restart,
    output logic            timer_enable,
    output logic      [1:0] charge_rate,
    output logic            usb_limit_select,
    output logic            usb_charge_allowed,
    output logic            charge_enable
);

    // ----------------------------------------
    // status input synchronisers
    // ----------------------------------------
    logic [15:0] sync1_reg;
    logic [15:0] sync2_reg;

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            sync1_reg <= 16'h0000;
            sync2_reg <= 16'h0000;
        end
        else
        begin
            sync1_reg <= {regulator_status_pin, charger_status_pin};
            sync2_reg <= sync1_reg;
        end
    end

    wire [7:0] charger_status   = sync2_reg[7:0];
    // reserved regulator position never raises anything
    wire [7:0] regulator_status = sync2_reg[15:8] & ~(8'h01 << pim_pkg::REG_RESERVED_BIT);

    // ----------------------------------------
    // writable registers
    // ----------------------------------------
    logic [7:0] charger_irq_mask_reg;
    logic [7:0] regulator_irq_mask_reg;
    logic [7:0] charger_configuration_reg;

    wire wr_chg_mask = reg_write & (reg_addr == pim_pkg::OFS_CHARGER_MASK);
    wire wr_reg_mask = reg_write & (reg_addr == pim_pkg::OFS_REGULATOR_MASK);
    wire wr_config   = reg_write & (reg_addr == pim_pkg::OFS_CHARGER_CONFIG);

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            charger_irq_mask_reg      <= pim_pkg::RST_MASK; // RULE14 RULE17
            regulator_irq_mask_reg    <= pim_pkg::RST_MASK; // RULE1 RULE2 RULE15 RULE17
            charger_configuration_reg <= pim_pkg::RST_CONFIG; // RULE11
        end
        else
        begin
            if (wr_chg_mask)
                charger_irq_mask_reg <= reg_wdata; // RULE14
            if (wr_reg_mask)
                regulator_irq_mask_reg <= reg_wdata; // RULE1 RULE2
            if (wr_config)
                charger_configuration_reg <= reg_wdata; // RULE11
        end
    end

    // ----------------------------------------
    // per-source flag and acknowledge
    // ----------------------------------------
    wire [15:0] all_cond = {regulator_status, charger_status};
    wire [15:0] all_mask = {regulator_irq_mask_reg, charger_irq_mask_reg};
    logic [15:0] pending;
    logic [15:0] ack_bits;
    logic [15:0] sel_onehot;

    // lowest pending index wins: charger register before regulator
    assign sel_onehot = pending & (~pending + 16'h0001); // RULE16

    // status read retires the source currently presented, if it is in that register
    wire rd_chg_status = reg_read & (reg_addr == pim_pkg::OFS_CHARGER_STATUS);
    wire rd_reg_status = reg_read & (reg_addr == pim_pkg::OFS_REGULATOR_STATUS);
    wire [15:0] ack_req = sel_onehot & {{8{rd_reg_status}}, {8{rd_chg_status}}}; // RULE16

    genvar gi;
    generate
        for (gi = 0; gi < pim_pkg::NUM_SOURCES; gi++)
        begin : g_src
            // RULE3 RULE4 RULE6 RULE7 RULE13
            pim_ack_bit u_bit
            (
                .clock   (clock),
                .sys_rst (sys_rst),
                .cond    (all_cond[gi]),
                .mask    (all_mask[gi]),
                .set_ack (ack_req[gi]),
                .pending (pending[gi]),
                .ack     (ack_bits[gi])
            );
        end
    endgenerate

    // ----------------------------------------
    // interrupt output
    // ----------------------------------------
    logic irq_n_reg;

    always_ff @(posedge clock)
    begin
        if (sys_rst)
            irq_n_reg <= 1'b1; // RULE17
        else
            irq_n_reg <= ~(|pending); // RULE5 RULE13
    end

    assign irq_n = irq_n_reg;

    // ----------------------------------------
    // read path
    // ----------------------------------------
    // ack registers are read-only: writes at these offsets fall through unused
    logic [7:0] rd_mux;

    always_comb
    begin
        case (reg_addr)
            pim_pkg::OFS_CHARGER_STATUS:   rd_mux = charger_status;
            pim_pkg::OFS_REGULATOR_STATUS: rd_mux = regulator_status;
            pim_pkg::OFS_CHARGER_MASK:     rd_mux = charger_irq_mask_reg;
            pim_pkg::OFS_REGULATOR_MASK:   rd_mux = regulator_irq_mask_reg;
            pim_pkg::OFS_CHARGER_ACK:      rd_mux = ack_bits[7:0]; // RULE8 RULE10
            pim_pkg::OFS_REGULATOR_ACK:    rd_mux = ack_bits[15:8]; // RULE9 RULE10
            pim_pkg::OFS_CHARGER_CONFIG:   rd_mux = charger_configuration_reg;
            default:                       rd_mux = pim_pkg::RST_ZERO;
        endcase
    end

    logic [7:0] rdata_reg;

    always_ff @(posedge clock)
    begin
        if (sys_rst)
            rdata_reg <= pim_pkg::RST_ZERO;
        else if (reg_read)
            rdata_reg <= rd_mux;
    end

    assign reg_rdata = rdata_reg;

    // ----------------------------------------
    // configuration fields
    // ----------------------------------------
    // RULE12
    assign auto_on_inhibit    = charger_configuration_reg[pim_pkg::CFG_AUTO_ON_INHIBIT];
    assign charger_restart    = charger_configuration_reg[pim_pkg::CFG_CHARGER_RESTART];
    assign timer_enable       = charger_configuration_reg[pim_pkg::CFG_TIMER_ENABLE];
    assign charge_rate        = charger_configuration_reg[pim_pkg::CFG_RATE_HI:pim_pkg::CFG_RATE_LO];
    assign usb_limit_select   = charger_configuration_reg[pim_pkg::CFG_USB_LIMIT_SEL];
    assign usb_charge_allowed = charger_configuration_reg[pim_pkg::CFG_USB_CHARGE_OK];
    assign charge_enable      = charger_configuration_reg[pim_pkg::CFG_CHARGE_ENABLE];

endmodule

// ===== tb/pim_host.sv
module pim_host
(
    input  wire logic       clock,
    input  wire logic [7:0] reg_rdata,
    output logic      [7:0] reg_addr,
    output logic      [7:0] reg_wdata,
    output logic            reg_write,
    output logic            reg_read
);
    timeunit 1ns;
    timeprecision 1ns;
    initial
    begin
        reg_addr  = 8'h00;
        reg_wdata = 8'h00;
        reg_write = 1'b0;
        reg_read  = 1'b0;
    end
    // caller sits at a falling edge; acknowledge offsets only for checks
    task automatic acc(input logic wr, input logic [7:0] a, d, output logic [7:0] q);
        reg_addr  = a;
        reg_wdata = d;
        reg_write = wr;
        reg_read  = !wr;
        @(negedge clock);
        reg_write = 1'b0;
        reg_read  = 1'b0;
        // released lines must not keep the last value
        reg_wdata = ~d;
        reg_addr  = ~a;
        @(negedge clock);
        q = reg_rdata;
    endtask
endmodule

// ===== tb/pim_irq_ctrl_asserts.sv
module pim_irq_asserts
(
    input wire logic       clock,
    input wire logic       sys_rst,
    input wire logic [7:0] charger_status_pin,
    input wire logic [7:0] regulator_status_pin,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_write,
    input wire logic       reg_read,
    input wire logic [7:0] reg_rdata,
    input wire logic       irq_n,
    input wire logic       auto_on_inhibit,
    input wire logic       charger_restart,
    input wire logic       timer_enable,
    input wire logic [1:0] charge_rate,
    input wire logic       usb_limit_select,
    input wire logic       usb_charge_allowed,
    input wire logic       charge_enable
);
    logic [7:0] cfg;
    logic       cfg_wr;
    logic       quiet;
    assign cfg = {auto_on_inhibit, charger_restart, timer_enable, charge_rate,
                  usb_limit_select, usb_charge_allowed, charge_enable};
    assign cfg_wr = reg_write && reg_addr == 8'h07;
    // reserved regulator bit 4 never counts as a cause
    assign quiet = charger_status_pin == 8'h00 && (regulator_status_pin & 8'hEF) == 8'h00;
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    AST_RST_IRQ: assert property ($fell(sys_rst) |-> irq_n)
        else $error("interrupt low after reset");
    AST_RST_CFG: assert property ($fell(sys_rst) |-> cfg == 8'h1B)
        else $error("config reset value wrong");
    AST_CFG_WRITE: assert property (cfg_wr |=> cfg == $past(reg_wdata))
        else $error("config field placement wrong");
    AST_CFG_KEEP: assert property (!cfg_wr |=> $stable(cfg))
        else $error("config changed without write");
    AST_CFG_HOLD: assert property (cfg_wr ##1 !cfg_wr [*3] |-> cfg == $past(reg_wdata, 3))
        else $error("config lost its value");
    AST_QUIET_HIGH: assert property (quiet [*6] |-> irq_n)
        else $error("interrupt low with no condition");
    // two sync stages, flag, output flop: the pin was sampled four edges back
    AST_IRQ_CAUSE: assert property ($fell(irq_n) |-> !$past(quiet, 4))
        else $error("interrupt fell without a condition");
    AST_MASK_RW: assert property (reg_write && reg_addr == 8'h04 ##2 reg_read && reg_addr == 8'h04
        |-> ##2 reg_rdata == $past(reg_wdata, 4))
        else $error("mask readback wrong");
    COV_IRQ: cover property ($fell(irq_n));
    COV_CFG: cover property (cfg_wr);
    COV_RISE: cover property ($rose(irq_n));
endmodule

bind pim_irq_ctrl pim_irq_asserts pim_irq_asserts_inst (.clock(clock), .sys_rst(sys_rst),
    .charger_status_pin(charger_status_pin), .regulator_status_pin(regulator_status_pin),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .irq_n(irq_n), .auto_on_inhibit(auto_on_inhibit),
    .charger_restart(charger_restart), .timer_enable(timer_enable), .charge_rate(charge_rate),
    .usb_limit_select(usb_limit_select), .usb_charge_allowed(usb_charge_allowed),
    .charge_enable(charge_enable));

// ===== tb/pim_irq_ctrl_test.sv
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin fail_count++; \
    $display("unexpected at %0t: got %h expected %h", $time, (a), (e)); end end
module pim_irq_ctrl_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic       clock = 1'b0;
    logic       sys_rst = 1'b1;
    logic [7:0] chg = 8'h00;
    logic [7:0] rsp = 8'h00;
    logic [7:0] addr, wdata, rdata, q;
    wire  [7:0] cfg;
    logic       wr, rd_s, irq_n;
    int         fail_count = 0;
    int         n_compared = 0;
    always #50 clock = ~clock;
    pim_host pim_host_inst (.clock(clock), .reg_rdata(rdata), .reg_addr(addr),
        .reg_wdata(wdata), .reg_write(wr), .reg_read(rd_s));
    pim_irq_ctrl pim_irq_ctrl_inst (.clock(clock), .sys_rst(sys_rst),
        .charger_status_pin(chg), .regulator_status_pin(rsp), .reg_addr(addr),
        .reg_wdata(wdata), .reg_write(wr), .reg_read(rd_s), .reg_rdata(rdata),
        .irq_n(irq_n), .auto_on_inhibit(cfg[7]), .charger_restart(cfg[6]),
        .timer_enable(cfg[5]), .charge_rate(cfg[4:3]), .usb_limit_select(cfg[2]),
        .usb_charge_allowed(cfg[1]), .charge_enable(cfg[0]));
    task automatic nw(input int n);
        repeat (n) @(negedge clock);
    endtask
    task automatic w(input logic [7:0] a, d);
        pim_host_inst.acc(1'b1, a, d, q);
    endtask
    task automatic r(input logic [7:0] a, e);
        pim_host_inst.acc(1'b0, a, 8'h00, q);
        `CHK(q, e);
    endtask
    task automatic give_verdict;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        nw(20);
        sys_rst = 1'b0;
        r(8'h03, 8'hFF);
        r(8'h04, 8'hFF);
        r(8'h05, 8'h00);
        r(8'h06, 8'h00);
        r(8'h07, 8'h1B);
        `CHK(irq_n, 1'b1);
        `CHK(cfg, 8'h1B);
        $display("reset test done");
        w(8'h07, 8'hE4);
        r(8'h07, 8'hE4);
        `CHK(cfg, 8'hE4);
        w(8'h05, 8'hFF);
        r(8'h05, 8'h00);
        w(8'h03, 8'h00);
        w(8'h04, 8'h01);
        r(8'h04, 8'h01);
        rsp = 8'h11;
        nw(8);
        `CHK(irq_n, 1'b1);
        rsp = 8'h00;
        nw(6);
        w(8'h04, 8'h00);
        $display("register test done");
        chg = 8'h04;
        rsp = 8'h02;
        nw(8);
        `CHK(irq_n, 1'b0);
        r(8'h01, 8'h04);
        nw(2);
        `CHK(irq_n, 1'b0);
        r(8'h05, 8'h04);
        r(8'h02, 8'h02);
        nw(2);
        r(8'h06, 8'h02);
        `CHK(irq_n, 1'b1);
        chg = 8'h00;
        rsp = 8'h00;
        nw(6);
        r(8'h05, 8'h00);
        r(8'h06, 8'h00);
        $display("acknowledge test done");
        give_verdict;
    end
    // generous bound; the sequence needs under a hundred cycles
    initial
    begin
        repeat (3000) @(posedge clock);
        fail_count++;
        give_verdict;
    end
endmodule
